// [ssp_serial_port.sv]
`timescale 1ns/100ps
`include "ssp_cfg.svh"
module ssp_serial_port
    import ssp_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // special function register port
    input wire ssp_sfr_req_s sfr_req,
    output logic [7:0] sfr_rdata,
    // interrupt
    input wire logic irq_enable,
    output logic irq,
    // serial pins
    input wire ssp_pin_in_s pins_in,
    output ssp_pin_out_s pins_out
);

    // ************************************************************
    // pin synchronisers
    // ************************************************************
    ssp_pin_in_s sync1;
    ssp_pin_in_s sync2;
    ssp_pin_in_s sync3;

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            sync1 <= '{sck: 1'b0, mosi: 1'b0, miso: 1'b0, sel_n: 1'b1};
            sync2 <= '{sck: 1'b0, mosi: 1'b0, miso: 1'b0, sel_n: 1'b1};
            sync3 <= '{sck: 1'b0, mosi: 1'b0, miso: 1'b0, sel_n: 1'b1};
        end
        else
        begin
            sync1 <= pins_in;
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end

    // ************************************************************
    // state
    // ************************************************************
    logic done, write_collision_flag, mode_fault_flag, ovr, master_enable_bit, port_enable_bit;
    logic cpha, cpol;
    logic [2:0] frs, bidx;
    logic [7:0] ckr, div, msh, mrx, rxbuf, ssh;
    logic [4:0] ecnt;
    logic rx_full, sck_lvl, slatch;
    logic [1:0] samp;
    ssp_mstate_e st;
    localparam logic [7:0] ctrl_rst = `SSP_CTRL_RESET;

    logic next_done, next_write_collision_flag, next_mode_fault_flag, next_ovr, next_master_enable_bit, next_port_enable_bit;
    logic next_cpha, next_cpol;
    logic [2:0] next_frs, next_bidx;
    logic [7:0] next_ckr, next_div, next_msh, next_mrx, next_rxbuf, next_ssh;
    logic [7:0] next_rdata;
    logic [4:0] next_ecnt;
    logic next_rx_full, next_sck_lvl, next_slatch;
    logic [1:0] next_samp;
    ssp_mstate_e next_st;

    logic wr_data, rd_data, slave_mode, slave_sel, sel_rise, lead, trail;
    logic busy, tick, fault;
    logic [4:0] nbits2;

    assign wr_data = sfr_req.wr && sfr_req.addr == `SSP_ADDR_DATA;
    assign rd_data = sfr_req.rd && sfr_req.addr == `SSP_ADDR_DATA;
    assign slave_mode = port_enable_bit && !master_enable_bit;
    assign slave_sel = slave_mode && !sync2.sel_n;
    assign sel_rise = !sync3.sel_n && sync2.sel_n;
    assign lead = sync3.sck == cpol && sync2.sck != cpol;
    assign trail = sync3.sck != cpol && sync2.sck == cpol;
    assign busy = st == M_RUN || slave_sel;
    // half period is ckr+1 clocks, so SCK never beats faster than clk/2
    assign tick = div == 8'h00;
    assign fault = master_enable_bit && !sync2.sel_n;
    assign nbits2 = {1'b0, frs, 1'b0} + 5'h02;

    // ************************************************************
    // next state
    // ************************************************************
    always_comb
    begin
        next_done = done;
        next_write_collision_flag = write_collision_flag;
        next_mode_fault_flag = mode_fault_flag;
        next_ovr = ovr;
        next_master_enable_bit = master_enable_bit;
        next_port_enable_bit = port_enable_bit;
        next_cpha = cpha;
        next_cpol = cpol;
        next_frs = frs;
        next_bidx = bidx;
        next_ckr = ckr;
        next_div = div;
        next_msh = msh;
        next_mrx = mrx;
        next_rxbuf = rxbuf;
        next_ssh = ssh;
        next_ecnt = ecnt;
        next_rx_full = rx_full;
        next_sck_lvl = sck_lvl;
        next_slatch = slatch;
        next_st = st;
        next_rdata = sfr_rdata;
        next_samp = {samp[0], 1'b0};

        // miso is taken two clocks after its sampling edge
        if (samp[1])
        begin
            next_mrx = {mrx[6:0], sync2.miso};
        end

        // software writes
        if (sfr_req.wr && sfr_req.addr == `SSP_ADDR_CTRL)
        begin
            next_done = sfr_req.wdata[`SSP_CTRL_DONE];
            next_write_collision_flag = sfr_req.wdata[`SSP_CTRL_WRITE_COLLISION_FLAG];
            next_mode_fault_flag = sfr_req.wdata[`SSP_CTRL_MODE_FAULT_FLAG];
            next_ovr = sfr_req.wdata[`SSP_CTRL_OVR];
            next_master_enable_bit = sfr_req.wdata[`SSP_CTRL_MASTER_ENABLE_BIT];
            next_port_enable_bit = sfr_req.wdata[`SSP_CTRL_PORT_ENABLE_BIT];
        end
        else if (sfr_req.wr && sfr_req.addr == `SSP_ADDR_CFG)
        begin
            next_cpha = sfr_req.wdata[`SSP_CFG_CPHA];
            next_cpol = sfr_req.wdata[`SSP_CFG_CPOL];
            next_frs = sfr_req.wdata[2:0];
        end
        else if (sfr_req.wr && sfr_req.addr == `SSP_ADDR_CKR)
        begin
            next_ckr = sfr_req.wdata;
        end
        else if (wr_data)
        begin
            if (busy)
            begin
                next_write_collision_flag = 1'b1;
            end
            else if (master_enable_bit && port_enable_bit && !fault)
            begin
                // left align so the word's top bit leaves first
                next_st = M_RUN;
                next_msh = sfr_req.wdata << (3'h7 - frs);
                next_bidx = frs;
                next_ecnt = 5'h00;
                next_div = ckr;
                next_mrx = 8'h00;
            end
            else
            begin
                next_ssh = sfr_req.wdata;
            end
        end

        if (rd_data)
        begin
            next_rx_full = 1'b0;
        end

        // master engine
        case (st)
            M_IDLE:
            begin
                next_sck_lvl = cpol;
            end
            M_RUN:
            begin
                if (!tick)
                begin
                    next_div = div - 8'h01;
                end
                else if (ecnt == nbits2 && !samp[0])
                begin
                    next_st = M_IDLE;
                    next_done = 1'b1;
                    next_rxbuf = next_mrx;
                    next_rx_full = 1'b1;
                end
                else if (ecnt == nbits2)
                begin
                    // last sample still in the synchroniser: wait a clock
                    next_st = M_RUN;
                end
                else
                begin
                    next_div = ckr;
                    next_sck_lvl = !sck_lvl;
                    next_ecnt = ecnt + 5'h01;
                    if (ecnt[0] == cpha)
                    begin
                        // the pin level at this edge shows on sync2 two
                        // clocks later, so the capture waits to match
                        next_samp[0] = 1'b1;
                    end
                    else if (ecnt != 5'h00 && ecnt != nbits2 - 5'h01)
                    begin
                        next_msh = {msh[6:0], 1'b0};
                        next_bidx = bidx - 3'h1;
                    end
                end
            end
            default:
            begin
                next_st = M_IDLE;
            end
        endcase

        // slave engine; phase 1 shifts straight in on the trailing edge
        if (slave_sel)
        begin
            if (lead && !cpha)
            begin
                next_slatch = sync2.mosi;
            end
            if (trail)
            begin
                next_ssh = {ssh[6:0], cpha ? sync2.mosi : slatch};
            end
        end
        if (sel_rise && slave_mode)
        begin
            next_done = 1'b1;
            if (rx_full)
            begin
                next_ovr = 1'b1;
            end
            else
            begin
                next_rxbuf = ssh;
                next_rx_full = 1'b1;
            end
        end

        // hardware wins over any software write in the same cycle
        if (fault)
        begin
            next_mode_fault_flag = 1'b1;
            next_master_enable_bit = 1'b0;
            next_port_enable_bit = 1'b0;
            next_st = M_IDLE;
        end

        // register reads
        if (sfr_req.rd)
        begin
            if (sfr_req.addr == `SSP_ADDR_CTRL)
            begin
                next_rdata = {done, write_collision_flag, mode_fault_flag, ovr, st == M_RUN,
                    !sync2.sel_n, master_enable_bit, port_enable_bit};
            end
            else if (sfr_req.addr == `SSP_ADDR_CFG)
            begin
                next_rdata = {cpha, cpol, bidx, frs};
            end
            else if (sfr_req.addr == `SSP_ADDR_DATA)
            begin
                next_rdata = rxbuf;
            end
            else if (sfr_req.addr == `SSP_ADDR_CKR)
            begin
                next_rdata = ckr;
            end
            else
            begin
                next_rdata = 8'h00;
            end
        end
    end

    // ************************************************************
    // registers
    // ************************************************************
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            {done, write_collision_flag, mode_fault_flag, ovr} <= 4'h0;
            master_enable_bit <= ctrl_rst[`SSP_CTRL_MASTER_ENABLE_BIT];
            port_enable_bit <= ctrl_rst[`SSP_CTRL_PORT_ENABLE_BIT];
            samp <= 2'b00;
            {cpha, cpol, bidx, frs} <= `SSP_CFG_RESET;
            ckr <= `SSP_CKR_RESET;
            div <= 8'h00;
            msh <= `SSP_DATA_RESET;
            mrx <= 8'h00;
            rxbuf <= `SSP_DATA_RESET;
            ssh <= `SSP_DATA_RESET;
            ecnt <= 5'h00;
            rx_full <= 1'b0;
            sck_lvl <= 1'b0;
            slatch <= 1'b0;
            st <= M_IDLE;
            sfr_rdata <= 8'h00;
        end
        else
        begin
            done <= next_done;
            write_collision_flag <= next_write_collision_flag;
            mode_fault_flag <= next_mode_fault_flag;
            ovr <= next_ovr;
            master_enable_bit <= next_master_enable_bit;
            port_enable_bit <= next_port_enable_bit;
            cpha <= next_cpha;
            cpol <= next_cpol;
            frs <= next_frs;
            bidx <= next_bidx;
            ckr <= next_ckr;
            div <= next_div;
            msh <= next_msh;
            mrx <= next_mrx;
            rxbuf <= next_rxbuf;
            ssh <= next_ssh;
            ecnt <= next_ecnt;
            rx_full <= next_rx_full;
            sck_lvl <= next_sck_lvl;
            slatch <= next_slatch;
            samp <= next_samp;
            st <= next_st;
            sfr_rdata <= next_rdata;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign pins_out.sck = sck_lvl;
    assign pins_out.sck_oe = master_enable_bit && port_enable_bit;
    assign pins_out.mosi = msh[7];
    assign pins_out.mosi_oe = master_enable_bit && port_enable_bit;
    assign pins_out.miso = ssh[7];
    assign pins_out.miso_oe = slave_sel;
    assign irq = done && irq_enable;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    chk_master_start: assert property (
        (wr_data && !busy && master_enable_bit && port_enable_bit && sync2.sel_n) |=> st == M_RUN)
        else $error("master write did not start a transfer");
    chk_master_end: assert property (
        (st == M_RUN && tick && ecnt == nbits2 && !samp[0] && !fault)
        |=> (done && st == M_IDLE && rxbuf == mrx))
        else $error("master end did not flag done with data");
    chk_frame_len: assert property (
        st == M_RUN |-> ecnt <= nbits2)
        else $error("master edge count beyond frame size");
    chk_write_collide: assert property (
        (wr_data && busy && !fault
            && !(st == M_RUN && tick && ecnt == nbits2))
        |=> (write_collision_flag && st == $past(st)))
        else $error("collision write not flagged");
    chk_mode_fault: assert property (
        (master_enable_bit && !sync2.sel_n) |=> (mode_fault_flag && !master_enable_bit && !port_enable_bit))
        else $error("mode fault did not take port off line");
    chk_slave_done: assert property (
        (sel_rise && slave_mode) |=> done)
        else $error("select release did not flag done");
    chk_overrun_keep: assert property (
        (sel_rise && slave_mode && rx_full) |=> (ovr && $stable(rxbuf)))
        else $error("overrun not flagged or buffer lost");
    chk_miso_float: assert property (
        sync2.sel_n |-> !pins_out.miso_oe)
        else $error("miso driven while not selected");
    chk_sck_idle: assert property (
        (st == M_IDLE && $past(st) == M_IDLE && $stable(cpol))
        |-> pins_out.sck == cpol)
        else $error("idle sck not at polarity level");
    chk_read_buf: assert property (
        rd_data |=> sfr_rdata == $past(rxbuf))
        else $error("data read did not return receive buffer");

endmodule

// [ssp_cfg.svh]
`ifndef SSP_CFG_SVH
`define SSP_CFG_SVH

// register addresses in the special function register space
`define SSP_ADDR_CTRL 8'hf8
`define SSP_ADDR_CFG 8'h9a
`define SSP_ADDR_DATA 8'h9b
`define SSP_ADDR_CKR 8'h9d

// reset values
`define SSP_CTRL_RESET 8'h00
`define SSP_CFG_RESET 8'h07
`define SSP_CKR_RESET 8'h00
`define SSP_DATA_RESET 8'h00

// control register fields
`define SSP_CTRL_DONE 7
`define SSP_CTRL_WRITE_COLLISION_FLAG 6
`define SSP_CTRL_MODE_FAULT_FLAG 5
`define SSP_CTRL_OVR 4
`define SSP_CTRL_MASTER_ENABLE_BIT 1
`define SSP_CTRL_PORT_ENABLE_BIT 0

// config register fields
`define SSP_CFG_CPHA 7
`define SSP_CFG_CPOL 6

`endif

// [ssp_pkg.sv]
package ssp_pkg;

    typedef enum logic [1:0] {
        M_IDLE = 2'b01,
        M_RUN = 2'b10
    } ssp_mstate_e;

    typedef struct packed {
        logic [7:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } ssp_sfr_req_s;

    typedef struct packed {
        logic sck;
        logic mosi;
        logic miso;
        logic sel_n;
    } ssp_pin_in_s;

    typedef struct packed {
        logic sck;
        logic sck_oe;
        logic mosi;
        logic mosi_oe;
        logic miso;
        logic miso_oe;
    } ssp_pin_out_s;

endpackage

// [ssp_peer_model.sv]
`timescale 1ns/100ps
// ********************************
// serial peer: slave or master
// ********************************
module ssp_peer_model (
    // clock
    input wire logic clk,
    // resolved lines
    input wire logic sck_w,
    input wire logic mosi_w,
    input wire logic miso_w,
    // peer drive
    output logic p_sck,
    output logic p_mosi,
    output logic p_miso,
    output logic p_sel_n
);
    logic pol = 1'b0;
    logic pha = 1'b0;
    logic lst = 1'b0;
    logic act = 1'b0;
    logic [7:0] tx = 8'h00;
    logic [7:0] rx = 8'h00;

    initial
    begin
        p_sck = 1'b0;
        p_mosi = 1'b0;
        p_miso = 1'b0;
        p_sel_n = 1'b1;
    end

    task automatic load(input logic [7:0] v, input logic cp, input logic ch);
        pol = cp;
        pha = ch;
        lst = cp;
        p_sck = cp;
        rx = 8'h00;
        tx = ch ? v : v << 1;
        p_miso = ch ? ~v[7] : v[7];
    endtask

    task automatic sel(input logic v);
        p_sel_n = v;
    endtask

    // slave role, edges taken straight from the resolved clock
    always @(sck_w)
    begin
        if (!act && sck_w !== lst)
        begin
            lst = sck_w;
            if ((sck_w !== pol) == pha)
            begin
                p_miso = tx[7];
                tx = tx << 1;
            end
            else
                rx = {rx[6:0], mosi_w};
        end
    end

    // a released line keeps changing so a stale bit never passes
    always @(posedge clk)
        if (act)
            p_miso <= ~p_miso;

    // master role, link clock of 800 ns, unrelated in phase
    task automatic xfer(input logic [7:0] v, output logic [7:0] got);
        act = 1'b1;
        p_sck = pol;
        #130;
        p_sel_n = 1'b0;
        #400;
        for (int i = 7; i >= 0; i--)
        begin
            if (!pha)
                p_mosi = v[i];
            #400;
            p_sck = ~pol;
            if (pha)
                p_mosi = v[i];
            else
                got[i] = miso_w;
            #400;
            p_sck = pol;
            if (pha)
                got[i] = miso_w;
        end
        #400;
        p_sel_n = 1'b1;
        p_mosi = ~p_mosi;
        #600;
        act = 1'b0;
    endtask
endmodule

// [ssp_serial_port_tb_top.sv]
`timescale 1ns/100ps
`include "ssp_cfg.svh"
module ssp_serial_port_tb_top
    import ssp_pkg::*;
;
    logic clk = 1'b0;
    logic reset = 1'b1;
    ssp_sfr_req_s req = '0;
    logic [7:0] rdata;
    logic irq_en = 1'b0;
    logic irq;
    ssp_pin_in_s pin_i;
    ssp_pin_out_s pin_o;
    logic p_sck, p_mosi, p_miso, p_sel_n;
    int err_total = 0;
    int checks = 0;
    logic [7:0] rd;
    logic [7:0] got;

    always #50 clk = ~clk;

    // ********************************
    // wire levels from all drivers
    // ********************************
    assign pin_i.sck = pin_o.sck_oe ? pin_o.sck : p_sck;
    assign pin_i.mosi = pin_o.mosi_oe ? pin_o.mosi : p_mosi;
    assign pin_i.miso = pin_o.miso_oe ? pin_o.miso : p_miso;
    assign pin_i.sel_n = p_sel_n;

    ssp_serial_port i_ssp_serial_port (
        .clk(clk),
        .reset(reset),
        .sfr_req(req),
        .sfr_rdata(rdata),
        .irq_enable(irq_en),
        .irq(irq),
        .pins_in(pin_i),
        .pins_out(pin_o)
    );

    ssp_peer_model i_ssp_peer_model (
        .clk(clk),
        .sck_w(pin_i.sck),
        .mosi_w(pin_i.mosi),
        .miso_w(pin_i.miso),
        .p_sck(p_sck),
        .p_mosi(p_mosi),
        .p_miso(p_miso),
        .p_sel_n(p_sel_n)
    );

    // ********************************
    // shared tasks
    // ********************************
    task automatic chk8(input string nm, input logic [7:0] e,
                        input logic [7:0] g);
        checks++;
        if (g !== e)
        begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        req.addr = a;
        req.wdata = d;
        req.wr = 1'b1;
        @(negedge clk);
        req.wr = 1'b0;
    endtask

    task automatic rdr(input logic [7:0] a);
        @(negedge clk);
        req.addr = a;
        req.rd = 1'b1;
        @(negedge clk);
        req.rd = 1'b0;
        rd = rdata;
    endtask

    task automatic waitirq(output int n);
        n = 0;
        while (irq !== 1'b1 && n < 3000)
        begin
            @(negedge clk);
            n++;
        end
    endtask

    // port is disabled while phase and polarity change
    task automatic setup(input logic [1:0] m, input logic [2:0] fr,
                         input logic [7:0] ckr, input logic [7:0] ctl);
        wr(`SSP_ADDR_CTRL, 8'h00);
        wr(`SSP_ADDR_CFG, {m, 3'b000, fr});
        wr(`SSP_ADDR_CKR, ckr);
        wr(`SSP_ADDR_CTRL, ctl);
    endtask

    task automatic complete_run;
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // ********************************
    // scenarios
    // ********************************
    task automatic t_reset;
        rdr(`SSP_ADDR_CFG);
        chk8("config", 8'h07, rd);
        rdr(`SSP_ADDR_CTRL);
        chk8("control", 8'h00, rd);
        rdr(`SSP_ADDR_CKR);
        chk8("rate", 8'h00, rd);
        rdr(8'h55);
        chk8("unmapped", 8'h00, rd);
        $display("reset test done");
    endtask

    task automatic t_master;
        int n;
        int c;
        logic [7:0] msk, d, v;
        logic [2:0] fr [4] = '{3'd7, 3'd0, 3'd4, 3'd2};
        irq_en = 1'b1;
        for (int m = 0; m < 4; m++)
        begin
            n = fr[m] + 1;
            msk = 8'hff >> (8 - n);
            d = 8'hb4 ^ 8'(m * 37);
            v = ~d;
            setup(m[1:0], fr[m], 8'(m), 8'h03);
            rdr(`SSP_ADDR_CTRL);
            chk8("bus free", 8'h03, rd);
            i_ssp_peer_model.load(v, m[0], m[1]);
            chk8("sck idle", {7'h0, m[0]}, {7'h0, pin_o.sck});
            wr(`SSP_ADDR_DATA, d);
            waitirq(c);
            chk8("latency", 8'((2*n+1)*(m+1)), 8'(c));
            chk8("peer rx", d & msk, i_ssp_peer_model.rx & msk);
            rdr(`SSP_ADDR_DATA);
            chk8("master rx", (v >> (8 - n)) & msk, rd & msk);
            rdr(`SSP_ADDR_CTRL);
            chk8("control", 8'h83, rd);
        end
        $display("master test done");
    endtask

    task automatic t_write_collision_flag;
        int c;
        setup(2'b00, 3'd7, 8'h0f, 8'h03);
        i_ssp_peer_model.load(8'h3c, 1'b0, 1'b0);
        wr(`SSP_ADDR_DATA, 8'ha7);
        rdr(`SSP_ADDR_CFG);
        chk8("bit count", 8'h3f, rd);
        wr(`SSP_ADDR_DATA, 8'h11);
        waitirq(c);
        rdr(`SSP_ADDR_CTRL);
        chk8("control", 8'hc3, rd);
        chk8("peer rx", 8'ha7, i_ssp_peer_model.rx);
        rdr(`SSP_ADDR_DATA);
        chk8("master rx", 8'h3c, rd);
        $display("collision test done");
    endtask

    task automatic t_mode_fault_flag;
        setup(2'b00, 3'd7, 8'h00, 8'h03);
        i_ssp_peer_model.sel(1'b0);
        repeat (6) @(negedge clk);
        rdr(`SSP_ADDR_CTRL);
        chk8("control", 8'h24, rd);
        i_ssp_peer_model.sel(1'b1);
        chk8("sck drive", 8'h00, {7'h0, pin_o.sck_oe});
        $display("mode fault test done");
    endtask

    // slow rate register set: it must not matter to a slave
    task automatic t_slave;
        logic [7:0] d, v;
        irq_en = 1'b0;
        for (int m = 0; m < 4; m++)
        begin
            d = 8'h96 ^ 8'(m * 51);
            v = 8'h3b + 8'(m * 29);
            setup(m[1:0], 3'd7, 8'hff, 8'h01);
            i_ssp_peer_model.load(8'h00, m[0], m[1]);
            wr(`SSP_ADDR_DATA, d);
            chk8("miso drive", 8'h00, {7'h0, pin_o.miso_oe});
            i_ssp_peer_model.xfer(v, got);
            chk8("peer got", d, got);
            rdr(`SSP_ADDR_CTRL);
            chk8("control", 8'h81, rd);
            chk8("irq masked", 8'h00, {7'h0, irq});
            rdr(`SSP_ADDR_DATA);
            chk8("slave rx", v, rd);
        end
        $display("slave test done");
    endtask

    task automatic t_overrun;
        setup(2'b00, 3'd7, 8'h00, 8'h01);
        i_ssp_peer_model.load(8'h00, 1'b0, 1'b0);
        i_ssp_peer_model.xfer(8'h71, got);
        i_ssp_peer_model.xfer(8'h2e, got);
        rdr(`SSP_ADDR_CTRL);
        chk8("control", 8'h91, rd);
        rdr(`SSP_ADDR_DATA);
        chk8("slave rx", 8'h71, rd);
        $display("overrun test done");
    endtask

    initial
    begin
        repeat (8) @(negedge clk);
        reset = 1'b0;
        t_reset;
        t_master;
        t_write_collision_flag;
        t_mode_fault_flag;
        t_slave;
        t_overrun;
        complete_run;
    end

    // all scenarios take well under a fifth of this span
    initial
    begin
        #1000000;
        err_total++;
        complete_run;
    end
endmodule
